// file: verilog/osc_pkg.sv
// constants and carrier types for the clock source control block
// assumes a byte-wide cpu memory bus and a single 100 MHz register clock
package osc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] PIN_MODE_ADDR  = 16'hFF9F;
  localparam logic [7:0]  PIN_MODE_RESET = 8'h00;
  localparam int          EXT_SEL_BIT    = 7;
  localparam int          HS_SEL_BIT     = 6;
  localparam int          SUB_SEL_BIT    = 4;
  // bits that hold state; bits 0 to 3 and 5 always read zero
  localparam logic [7:0]  PIN_MODE_MASK  = 8'hD0;

  // ----------------------------------------------------------------
  // nominal source rates, kept for reference by users of the block
  // ----------------------------------------------------------------
  localparam int HI_INT_FREQ_KHZ  = 8000;
  localparam int EXT_MIN_FREQ_KHZ = 2000;
  localparam int EXT_MAX_FREQ_KHZ = 10000;
  localparam int SUB_FREQ_HZ      = 32768;
  localparam int LOW_FREQ_KHZ     = 240;

  // ----------------------------------------------------------------
  // low-speed clock dividers
  // ----------------------------------------------------------------
  localparam int          LOW_DIV_WIDTH = 9;
  localparam logic [8:0]  LOW_DIV_128   = 9'h007F;
  localparam logic [8:0]  LOW_DIV_512   = 9'h01FF;
  localparam logic [8:0]  LOW_DIV_8     = 9'h0007;

  // ----------------------------------------------------------------
  // option strap timing
  // ----------------------------------------------------------------
  // edges after reset release before the strap synchroniser is full
  localparam logic [1:0]  OPT_SETTLE_EDGES = 2'h2;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_PORT  = 2'b00,
    HS_RESON = 2'b01,
    HS_EXT   = 2'b10
  } osc_hs_mode_type;

  typedef enum logic [1:0] {
    CPU_SRC_INT_HI = 2'b00,
    CPU_SRC_HIGH   = 2'b01,
    CPU_SRC_SUB    = 2'b10
  } osc_cpu_src_type;

  typedef enum logic [1:0] {
    TMR_SRC_NONE   = 2'b00,
    TMR_SRC_LOW    = 2'b01,
    TMR_SRC_LOW128 = 2'b10,
    TMR_SRC_LOW512 = 2'b11
  } osc_tmr_src_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic        wrEn;
    logic        bitOp;
    logic [2:0]  bitIdx;
    logic        bitVal;
    logic [7:0]  wrData;
    logic        rdEn;
  } osc_bus_req_type;

  typedef struct packed {
    logic [7:0] rdData;
    logic       rdHit;
  } osc_bus_rsp_type;

  typedef struct packed {
    logic hiIntOscEn;
    logic x1OscEn;
    logic extClkInEn;
    logic subOscEn;
    logic lowOscEn;
  } osc_enables_type;

endpackage : osc_pkg

// file: verilog/osc_sync.sv
// two-stage synchroniser for a group of asynchronous levels
// assumes inputs may change at any time relative to ref_clk
`timescale 1ns/100ps
module osc_sync
  import osc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } osc_sync_state_type;

  osc_sync_state_type state_q;
  osc_sync_state_type state_d;

  // only the second stage is visible to logic
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < WIDTH; i++) begin
      state_d.stage1[i] = asyncIn[i];
      state_d.stage2[i] = state_q.stage1[i];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;

endmodule : osc_sync

// file: verilog/osc_pin_decode.sv
// decodes the clock pin-mode selects into pin operating modes
// purely combinational; fed from the pin-mode register
`timescale 1ns/100ps
module osc_pin_decode
  import osc_pkg::*;
(
  // select bits
  input  wire logic      extSel,
  input  wire logic      hsSel,
  input  wire logic      subSel,
  // decoded modes
  output osc_hs_mode_type hsMode,
  output logic           subCrystal
);

  always_comb begin
    // ext select alone does nothing: pins stay ports
    if (hsSel && extSel) begin
      hsMode = HS_EXT;
    end else if (hsSel) begin
      hsMode = HS_RESON;
    end else begin
      hsMode = HS_PORT;
    end
  end

  assign subCrystal = subSel;

endmodule : osc_pin_decode

// file: verilog/osc_source_ctrl.sv
// clock source control: pin-mode register, oscillator enables,
// cpu source selection and low-speed clock distribution
// assumes a byte-wide cpu bus on ref_clk; other clock registers
// live elsewhere and arrive here as plain control levels
//
// Functional notes
// - cpu starts on internal 8 MHz oscillator
// - internal high oscillator stops on STOP or control
// - external 2-10 MHz clock input, stoppable
// - main clock from high-speed or internal oscillator
// - 32.768 kHz sub oscillator, stoppable by controls
// - low-speed 240 kHz oscillator runs after reset
// - low-speed stop honoured only if option allows
// - low-speed clock never drives the cpu
// - low clock feeds watchdog, timer, lcd
// - pin-mode register at FF9F, resets to zero
// - register takes bit and byte writes
// - ext and pin selects decode pin mode
// - bit 4 selects sub crystal mode
`timescale 1ns/100ps
module osc_source_ctrl
  import osc_pkg::*;
(
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  // cpu register bus
  input  osc_bus_req_type      busReq,
  output osc_bus_rsp_type      busRsp,
  // controls held by neighbouring clock registers
  input  wire logic            stopInstr,
  input  wire logic            intHiStopReq,
  input  wire logic            lowStopReq,
  input  wire logic            mainOscStopBit,
  input  wire logic            mainSelHigh,
  input  wire logic            cpuOnSubclockStatus,
  input  wire logic            subStopCtrl,
  input  wire logic            optLowStoppable,
  // peripheral clock choices
  input  osc_tmr_src_type      tmrLowSrc,
  input  wire logic            lcdLowSrc,
  // raw low-speed oscillator output
  input  wire logic            lowOscClk,
  // oscillator and pin controls
  output osc_enables_type      oscEn,
  output osc_hs_mode_type      hsPinMode,
  output logic                 subPinCrystal,
  // clock routing
  output osc_cpu_src_type      cpuSrc,
  output logic                 wdtLowTick,
  output logic                 tmrLowTick,
  output logic                 lcdLowTick
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]               pinMode;
    osc_bus_rsp_type          rsp;
    osc_enables_type          en;
    osc_cpu_src_type          cpuSrc;
    logic                     optSeen;
    logic                     optAllow;
    logic [1:0]               optWait;
    logic                     lowPrev;
    logic [LOW_DIV_WIDTH-1:0] lowDiv;
    logic                     wdtTick;
    logic                     tmrTick;
    logic                     lcdTick;
  } osc_state_type;

  osc_state_type state_q;
  osc_state_type state_d;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  // the option strap and the oscillator output come from off-domain
  logic [1:0] syncLevels;

  osc_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .asyncIn ({optLowStoppable, lowOscClk}),
    .syncOut (syncLevels)
  );

  logic optSync;
  logic lowSync;
  assign optSync = syncLevels[1];
  assign lowSync = syncLevels[0];

  // ----------------------------------------------------------------
  // pin mode decode
  // ----------------------------------------------------------------
  osc_hs_mode_type hsMode;
  logic            subCrystal;

  osc_pin_decode u_decode (
    .extSel     (state_q.pinMode[EXT_SEL_BIT]),
    .hsSel      (state_q.pinMode[HS_SEL_BIT]),
    .subSel     (state_q.pinMode[SUB_SEL_BIT]),
    .hsMode     (hsMode),
    .subCrystal (subCrystal)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addrHit(input logic [15:0] a);
    addrHit = (a == PIN_MODE_ADDR);
  endfunction : addrHit

  // bit op touches one bit; byte write replaces all
  function automatic logic [7:0] applyWrite(input logic [7:0] cur,
                                            input osc_bus_req_type r);
    logic [7:0] nv;
    nv = cur;
    if (r.bitOp) begin
      nv[r.bitIdx] = r.bitVal;
    end else begin
      nv = r.wrData;
    end
    applyWrite = nv & PIN_MODE_MASK;
  endfunction : applyWrite

  // true on the last count of a power-of-two divider window
  function automatic logic divTap(input logic [LOW_DIV_WIDTH-1:0] cnt,
                                  input logic [LOW_DIV_WIDTH-1:0] last);
    divTap = ((cnt & last) == last);
  endfunction : divTap

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic wrHit;
  logic rdHit;
  logic lowRise;
  logic lowStopNow;
  logic optReady;
  logic mainInGate;

  assign wrHit      = busReq.wrEn && addrHit(busReq.addr);
  assign rdHit      = busReq.rdEn && addrHit(busReq.addr);
  assign lowRise    = lowSync && !state_q.lowPrev;
  // the synchroniser is reset too, so its output only shows the
  // real strap level once two edges have passed since release
  assign optReady   = (state_q.optWait == OPT_SETTLE_EDGES);
  // both main-clock inputs share the same stop conditions
  assign mainInGate = !mainOscStopBit && !stopInstr;

  always_comb begin
    state_d    = state_q;
    lowStopNow = 1'b0;

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    // a read and a write in one cycle: the read sees the old value
    if (wrHit) begin
      // unused bits are forced to zero whatever software writes
      state_d.pinMode = applyWrite(state_q.pinMode, busReq);
    end
    state_d.rsp = '0;
    if (rdHit) begin
      state_d.rsp.rdData = state_q.pinMode & PIN_MODE_MASK;
      state_d.rsp.rdHit  = 1'b1;
    end

    // ----------------------------------------------------------------
    // option strap
    // ----------------------------------------------------------------
    // caught once, as soon as the synchroniser holds the real level
    if (!optReady) begin
      state_d.optWait = state_q.optWait + 2'h1;
    end
    if (optReady && !state_q.optSeen) begin
      state_d.optSeen  = 1'b1;
      state_d.optAllow = optSync;
    end

    // ----------------------------------------------------------------
    // oscillator enables
    // ----------------------------------------------------------------
    state_d.en.hiIntOscEn = !(stopInstr || intHiStopReq);
    // mode changes are only safe with main oscillator stopped;
    // this block does not police it, it just follows the mode
    state_d.en.x1OscEn    = (hsMode == HS_RESON) && mainInGate;
    state_d.en.extClkInEn = (hsMode == HS_EXT) && mainInGate;
    state_d.en.subOscEn   = subCrystal && !subStopCtrl;
    lowStopNow            = lowStopReq && state_q.optSeen && state_q.optAllow;
    state_d.en.lowOscEn   = !lowStopNow;

    // ----------------------------------------------------------------
    // cpu source
    // ----------------------------------------------------------------
    // low-speed clock is not an option here at all
    if (cpuOnSubclockStatus) begin
      state_d.cpuSrc = CPU_SRC_SUB;
    end else if (mainSelHigh) begin
      state_d.cpuSrc = CPU_SRC_HIGH;
    end else begin
      state_d.cpuSrc = CPU_SRC_INT_HI;
    end

    // ----------------------------------------------------------------
    // low-speed distribution
    // ----------------------------------------------------------------
    // ticks trail the pin edge by about three cycles; a low clock
    // faster than half of ref_clk would lose rises here
    state_d.lowPrev = lowSync;
    state_d.wdtTick = 1'b0;
    state_d.tmrTick = 1'b0;
    state_d.lcdTick = 1'b0;
    if (lowRise && state_q.en.lowOscEn) begin
      state_d.lowDiv  = state_q.lowDiv + 9'h0001;
      state_d.wdtTick = 1'b1;
      case (tmrLowSrc)
        TMR_SRC_LOW: begin
          state_d.tmrTick = 1'b1;
        end
        TMR_SRC_LOW128: begin
          state_d.tmrTick = divTap(state_q.lowDiv, LOW_DIV_128);
        end
        TMR_SRC_LOW512: begin
          state_d.tmrTick = divTap(state_q.lowDiv, LOW_DIV_512);
        end
        default: begin
          state_d.tmrTick = 1'b0;
        end
      endcase
      state_d.lcdTick = lcdLowSrc && divTap(state_q.lowDiv, LOW_DIV_8);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // both always-on sources come up enabled, so the cpu has a clock
  // and the watchdog its ticks straight out of reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q               <= '0;
      state_q.pinMode       <= PIN_MODE_RESET;
      state_q.en.hiIntOscEn <= 1'b1;
      state_q.en.lowOscEn   <= 1'b1;
      state_q.cpuSrc        <= CPU_SRC_INT_HI;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busRsp        = state_q.rsp;
  assign oscEn         = state_q.en;
  assign hsPinMode     = hsMode;
  assign subPinCrystal = subCrystal;
  assign cpuSrc        = state_q.cpuSrc;
  assign wdtLowTick    = state_q.wdtTick;
  assign tmrLowTick    = state_q.tmrTick;
  assign lcdLowTick    = state_q.lcdTick;

endmodule : osc_source_ctrl

// file: tb/osc_source_ctrl_props.sv
// assertions on the clock source control block
// bound onto osc_source_ctrl; sees its ports only
`timescale 1ns/100ps
module osc_source_ctrl_props
  import osc_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // bus and controls
  input osc_bus_req_type busReq,
  input osc_bus_rsp_type busRsp,
  input wire logic       stopInstr,
  input wire logic       intHiStopReq,
  input wire logic       lowStopReq,
  input wire logic       mainOscStopBit,
  input wire logic       mainSelHigh,
  input wire logic       cpuOnSubclockStatus,
  input wire logic       lowOscClk,
  // outputs
  input osc_enables_type oscEn,
  input osc_hs_mode_type hsPinMode,
  input wire logic       subPinCrystal,
  input osc_cpu_src_type cpuSrc,
  input wire logic       wdtLowTick,
  input wire logic       tmrLowTick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic rdReq = busReq.rdEn && busReq.addr == PIN_MODE_ADDR;
  wire logic wrHit = busReq.wrEn && busReq.addr == PIN_MODE_ADDR && !busReq.bitOp;

  function automatic osc_hs_mode_type dec(logic [1:0] s);
    return s == 2'b11 ? HS_EXT : s == 2'b01 ? HS_RESON : HS_PORT;
  endfunction : dec

  a_cpu_sub_first: assert property (cpuOnSubclockStatus |=> cpuSrc == CPU_SRC_SUB)
    else $error("cpu source not sub");
  a_cpu_high_next: assert property (!cpuOnSubclockStatus && mainSelHigh |=> cpuSrc == CPU_SRC_HIGH)
    else $error("cpu source not high");
  a_cpu_int_default: assert property (!cpuOnSubclockStatus && !mainSelHigh |=> cpuSrc == CPU_SRC_INT_HI)
    else $error("cpu source not internal");
  a_never_low: assert property (cpuSrc != 2'b11)
    else $error("illegal cpu source");
  a_hi_stop: assert property (stopInstr || intHiStopReq |=> !oscEn.hiIntOscEn)
    else $error("internal oscillator kept running");
  a_ext_gate: assert property (stopInstr || mainOscStopBit |=> !oscEn.extClkInEn && !oscEn.x1OscEn)
    else $error("main input not gated");
  a_pin_write: assert property (wrHit |=> hsPinMode == dec($past(busReq.wrData[7:6])) && subPinCrystal == $past(busReq.wrData[4]))
    else $error("pin mode not decoded");
  a_read_hit: assert property (rdReq |=> busRsp.rdHit && (busRsp.rdData & ~PIN_MODE_MASK) == 8'h00)
    else $error("read answer wrong");
  a_read_miss: assert property (busReq.rdEn && !rdReq |=> !busRsp.rdHit && busRsp.rdData == 8'h00)
    else $error("foreign address answered");
  a_low_run: assert property (!lowStopReq |=> oscEn.lowOscEn)
    else $error("low oscillator stopped");
  a_wdt_tick: assert property ($rose(lowOscClk) && oscEn.lowOscEn |-> ##[1:4] wdtLowTick)
    else $error("watchdog tick missing");
  a_tmr_on_rise: assert property (tmrLowTick |-> wdtLowTick)
    else $error("timer tick off a rise");

  c_write: cover property (wrHit);
  c_tmr: cover property (tmrLowTick);
  c_sub: cover property (cpuSrc == CPU_SRC_SUB);
endmodule : osc_source_ctrl_props

bind osc_source_ctrl osc_source_ctrl_props i_osc_source_ctrl_props (
  .ref_clk             (ref_clk),
  .arst_n              (arst_n),
  .busReq              (busReq),
  .busRsp              (busRsp),
  .stopInstr           (stopInstr),
  .intHiStopReq        (intHiStopReq),
  .lowStopReq          (lowStopReq),
  .mainOscStopBit      (mainOscStopBit),
  .mainSelHigh         (mainSelHigh),
  .cpuOnSubclockStatus (cpuOnSubclockStatus),
  .lowOscClk           (lowOscClk),
  .oscEn               (oscEn),
  .hsPinMode           (hsPinMode),
  .subPinCrystal       (subPinCrystal),
  .cpuSrc              (cpuSrc),
  .wdtLowTick          (wdtLowTick),
  .tmrLowTick          (tmrLowTick)
);

// file: tb/osc_low_model.sv
// low-speed oscillator model driving the raw clock pin
// assumes the block's low enable as its run control
`timescale 1ns/100ps
module osc_low_model #(
  parameter int HALF = 4
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // control and pin
  input  wire logic runEn,
  output logic      lowClk
);
  int cnt;
  // stepped on ref_clk; the block only cares that it is slow
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      lowClk <= 1'b0;
    end else if (runEn) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) lowClk <= !lowClk;
    end
  end
endmodule : osc_low_model

// file: tb/testbench.sv
// self-checking bench for the clock source control block
// assumes the checker is bound in from its own file
`timescale 1ns/100ps
module testbench
  import osc_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, stopInstr = 1'b0, intHiStopReq = 1'b0;
  logic lowStopReq = 1'b0, mainOscStopBit = 1'b1, mainSelHigh = 1'b0;
  logic cpuOnSubclockStatus = 1'b0, subStopCtrl = 1'b0, optLowStoppable = 1'b0;
  logic lcdLowSrc = 1'b0, lowOscClk, subPinCrystal, wdtLowTick, tmrLowTick, lcdLowTick;
  osc_tmr_src_type tmrLowSrc = TMR_SRC_LOW;
  osc_bus_req_type busReq = '0;
  osc_bus_rsp_type busRsp;
  osc_enables_type oscEn;
  osc_hs_mode_type hsPinMode;
  osc_cpu_src_type cpuSrc;
  int fails = 0, checked = 0;
  logic [7:0] rdv;
  osc_source_ctrl i_osc_source_ctrl (
    .ref_clk             (ref_clk),
    .arst_n              (arst_n),
    .busReq              (busReq),
    .busRsp              (busRsp),
    .stopInstr           (stopInstr),
    .intHiStopReq        (intHiStopReq),
    .lowStopReq          (lowStopReq),
    .mainOscStopBit      (mainOscStopBit),
    .mainSelHigh         (mainSelHigh),
    .cpuOnSubclockStatus (cpuOnSubclockStatus),
    .subStopCtrl         (subStopCtrl),
    .optLowStoppable     (optLowStoppable),
    .tmrLowSrc           (tmrLowSrc),
    .lcdLowSrc           (lcdLowSrc),
    .lowOscClk           (lowOscClk),
    .oscEn               (oscEn),
    .hsPinMode           (hsPinMode),
    .subPinCrystal       (subPinCrystal),
    .cpuSrc              (cpuSrc),
    .wdtLowTick          (wdtLowTick),
    .tmrLowTick          (tmrLowTick),
    .lcdLowTick          (lcdLowTick)
  );
  osc_low_model i_osc_low_model (.ref_clk, .arst_n, .runEn(oscEn.lowOscEn), .lowClk(lowOscClk));
  always #5 ref_clk = !ref_clk;

  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask : settle
  task automatic wr(input logic b, input logic [2:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{PIN_MODE_ADDR, 1'b1, b, i, d[0], d, 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic hit);
    @(posedge ref_clk);
    busReq <= '{a, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00, 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    @(negedge ref_clk);
    chk(busRsp.rdData, exp);
    chk(busRsp.rdHit, hit);
  endtask : rd

  task automatic t_reset;
    rd(PIN_MODE_ADDR, PIN_MODE_RESET, 1'b1);
    chk({cpuSrc, oscEn.hiIntOscEn, oscEn.lowOscEn}, 4'b0011);
  endtask : t_reset
  task automatic t_modes;
    for (int k = 0; k < 4; k++) begin
      wr(1'b0, 3'h0, {k[1:0], 6'h10}); // main stopped, cpu on main
      rd(PIN_MODE_ADDR, {k[1:0], 6'h10}, 1'b1);
      chk(hsPinMode, k == 3 ? HS_EXT : k == 1 ? HS_RESON : HS_PORT);
      chk(subPinCrystal, 1'b1);
    end
    wr(1'b1, 3'h4, 8'h00);
    rd(PIN_MODE_ADDR, 8'hC0, 1'b1);
    wr(1'b1, 3'h7, 8'h00);
    rd(PIN_MODE_ADDR, 8'h40, 1'b1);
    chk(hsPinMode, HS_RESON);
    wr(1'b0, 3'h0, 8'hD0);
    rd(16'hFFA0, 8'h00, 1'b0);
  endtask : t_modes
  task automatic t_stop;
    @(posedge ref_clk);
    mainOscStopBit <= 1'b0;
    settle;
    chk({oscEn.extClkInEn, oscEn.x1OscEn, oscEn.subOscEn}, 3'b101);
    @(posedge ref_clk);
    stopInstr <= 1'b1;
    subStopCtrl <= 1'b1;
    settle;
    chk({oscEn.hiIntOscEn, oscEn.extClkInEn, oscEn.subOscEn}, 3'b000);
    @(posedge ref_clk);
    stopInstr <= 1'b0;
    intHiStopReq <= 1'b1;
    settle;
    chk({oscEn.hiIntOscEn, oscEn.extClkInEn}, 2'b01);
    @(posedge ref_clk);
    intHiStopReq <= 1'b0;
    mainOscStopBit <= 1'b1;
  endtask : t_stop
  task automatic t_cpu;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      {cpuOnSubclockStatus, mainSelHigh} <= k[1:0];
      settle;
      chk(cpuSrc, k > 1 ? CPU_SRC_SUB : k == 1 ? CPU_SRC_HIGH : CPU_SRC_INT_HI);
    end
  endtask : t_cpu
  task automatic t_gap(input logic [1:0] s, input logic lcd, input int exp);
    int n;
    bit started;
    n = 0;
    started = 0;
    @(posedge ref_clk);
    tmrLowSrc <= osc_tmr_src_type'(s);
    lcdLowSrc <= lcd;
    settle;
    // the budget covers two full /512 periods of the model
    for (int w = 0; w < 10000; w++) begin
      @(negedge ref_clk);
      if (started && wdtLowTick) n++;
      if (lcd ? lcdLowTick : tmrLowTick) begin
        if (started) break;
        started = 1;
      end
    end
    chk(n, exp);
  endtask : t_gap
  task automatic t_lowstop;
    @(posedge ref_clk);
    lowStopReq <= 1'b1;
    settle;
    chk(oscEn.lowOscEn, 1'b1);
    @(posedge ref_clk);
    optLowStoppable <= 1'b1;
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    // strap is taken once the synchroniser is full, enable one edge later
    repeat (6) @(negedge ref_clk);
    chk(oscEn.lowOscEn, 1'b0);
    rd(PIN_MODE_ADDR, PIN_MODE_RESET, 1'b1);
  endtask : t_lowstop

  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset;
    t_modes;
    t_stop;
    t_cpu;
    t_gap(2'b01, 1'b0, 1);
    t_gap(2'b10, 1'b0, 128);
    t_gap(2'b11, 1'b0, 512);
    t_gap(2'b01, 1'b1, 8);
    t_lowstop;
    close_out;
  end
  // about 8k cycles of tests; allow well over four times that
  initial begin
    #400us;
    fails++;
    close_out;
  end
endmodule : testbench
